// ===== rtl/phy_status_pkg.sv
package phy_status_pkg;

    // =====================================================================
    // Register map
    localparam logic [7:0] summary_offset = 8'hc0;
    localparam logic [7:0] false_carrier_counter_offset = 8'hd0;
    localparam logic [7:0] receive_error_counter_offset = 8'hd4;
    localparam logic [7:0] addr_mask = 8'hfc;
    localparam logic [15:0] summary_reset = 16'h0000;
    localparam logic [31:0] unmapped_read_value = 32'h0000_0000;

    // =====================================================================
    // Field positions in the summary word
    localparam int rx_err_bit = 13;
    localparam int polarity_bit = 12;
    localparam int false_carrier_bit = 11;
    localparam int signal_detect_bit = 10;
    localparam int descr_lock_bit = 9;
    localparam int page_rx_bit = 8;
    localparam int intr_pend_bit = 7;
    localparam int remote_fault_bit = 6;
    localparam int jabber_bit = 5;
    localparam int an_done_bit = 4;
    localparam int loopback_bit = 3;
    localparam int duplex_bit = 2;
    localparam int speed10_bit = 1;
    localparam int link_bit = 0;

    // =====================================================================
    // AXI responses
    localparam logic [1:0] resp_okay = 2'b00;
    localparam logic [1:0] resp_slverr = 2'b10;

endpackage : phy_status_pkg

// ===== rtl/phy_status_summary_reg.sv
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// R1: 16-bit read-only summary register at 0xc0, zero after reset.
// R2: Bits 15:14 read zero; writes are ignored.
// R3: Bit 13 latches receive errors; cleared by reading receive error counter.
// R4: Bit 12 mirrors 10BASE-T polarity flag; summary read does not clear it.
// R5: Bit 11 latches false carrier; cleared by reading false carrier counter.
// R6: Bit 10 is latch-low signal detect, zero at reset.
// R7: Bit 9 is latch-low descrambler lock, zero at reset.
// R8: Bit 8 mirrors autoneg page-received flag; summary read leaves it.
// R9: Bit 7 latches pending interrupt; cleared by the summary read returning it.
// R10: Bit 6 remote fault, cleared by basic status read or reset.
// R11: Bit 5 mirrors jabber flag; summary read does not clear it.
// R12: Bit 4 shows auto-negotiation complete.
// R13: Bit 3 shows loopback enabled.
// R14: Bit 2 shows resolved duplex, one is full.
// R15: Bit 1 shows resolved speed, one is 10 Mb/s.
// R16: Software trusts duplex and speed only with valid link conditions.
// R17: Bit 0 mirrors basic status link flag; summary read does not clear it.
module phy_status_summary_reg (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // One-cycle events from PHY logic on core_clk
    input wire logic rx_error_event,
    input wire logic false_carrier_event,
    input wire logic phy_intr_event,
    // Mirrored flags from neighbouring registers on core_clk
    input wire logic polarity_inverted,
    input wire logic page_received,
    input wire logic remote_fault,
    input wire logic jabber_detect,
    input wire logic link_status,
    // Resolved PHY state on core_clk
    input wire logic an_complete,
    input wire logic loopback_en,
    input wire logic duplex_full,
    input wire logic speed_10,
    // PMD indications from the analog side, asynchronous
    input wire logic signal_detect_pin,
    input wire logic descr_lock_pin,
    // Clear-on-read strobes for the latched bits
    output logic rx_err_counter_read,
    output logic false_carrier_counter_read,
    output logic summary_read
);

    // =====================================================================
    // Bus state
    logic aw_held_ff;
    logic w_held_ff;
    logic aw_hit_ff;
    logic ar_done;
    logic [7:0] rd_addr;
    logic [1:0] pmd_sync;
    logic rx_err_ff;
    logic false_carrier_ff;
    logic intr_pend_ff;
    logic signal_detect_ff;
    logic descr_lock_ff;
    logic [15:0] summary_word;

    function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] offset);
        return (addr & phy_status_pkg::addr_mask) == offset;
    endfunction : addr_is

    // =====================================================================
    // Write channel: accepted in any order, always answered
    // Only one write outstanding, so readies drop while a response waits
    assign s_axi_awready = !aw_held_ff && !s_axi_bvalid;
    assign s_axi_wready = !w_held_ff && !s_axi_bvalid;

    // Hold address and data acceptance until both have arrived
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            aw_hit_ff <= 1'b0;
        end else if ((aw_held_ff || (s_axi_awvalid && s_axi_awready))
                     && (w_held_ff || (s_axi_wvalid && s_axi_wready))) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_ff <= 1'b1;
                aw_hit_ff <= addr_is(s_axi_awaddr, phy_status_pkg::summary_offset);
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_ff <= 1'b1;
            end
        end
    end

    // Write response: summary is read-only, so data is dropped and OKAY given;
    // any other address of this block answers SLVERR
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= phy_status_pkg::resp_okay;
        end else if (s_axi_bvalid) begin
            if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end else if ((aw_held_ff || (s_axi_awvalid && s_axi_awready))
                     && (w_held_ff || (s_axi_wvalid && s_axi_wready))) begin
            s_axi_bvalid <= 1'b1;
            if (aw_held_ff ? aw_hit_ff
                           : addr_is(s_axi_awaddr, phy_status_pkg::summary_offset)) begin
                s_axi_bresp <= phy_status_pkg::resp_okay; // R2
            end else begin
                s_axi_bresp <= phy_status_pkg::resp_slverr;
            end
        end
    end

    // =====================================================================
    // Read channel
    assign s_axi_arready = !s_axi_rvalid;
    assign ar_done = s_axi_arvalid && s_axi_arready;
    assign rd_addr = s_axi_araddr;

    // Clear strobes fire on the accepted read so the returned data holds
    // the latched value and the clear lands afterwards
    assign summary_read = ar_done && addr_is(rd_addr, phy_status_pkg::summary_offset);
    assign rx_err_counter_read = ar_done
        && addr_is(rd_addr, phy_status_pkg::receive_error_counter_offset);
    assign false_carrier_counter_read = ar_done
        && addr_is(rd_addr, phy_status_pkg::false_carrier_counter_offset);

    // Read data captured from the live word on acceptance
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= phy_status_pkg::unmapped_read_value;
            s_axi_rresp <= phy_status_pkg::resp_okay;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else if (ar_done) begin
            s_axi_rvalid <= 1'b1;
            if (summary_read) begin
                s_axi_rdata <= {16'h0000, summary_word}; // R1
                s_axi_rresp <= phy_status_pkg::resp_okay;
            end else begin
                s_axi_rdata <= phy_status_pkg::unmapped_read_value;
                s_axi_rresp <= phy_status_pkg::resp_slverr;
            end
        end
    end

    // =====================================================================
    // Latched bits
    // PMD levels come from another domain, so synchronise first
    sync2 #(
        .WIDTH(2)
    ) u_pmd_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .async_in({signal_detect_pin, descr_lock_pin}),
        .sync_ff(pmd_sync)
    );

    status_latch #(.LATCH_LOW(1'b0)) u_rx_err (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .event_in(rx_error_event),
        .clear(rx_err_counter_read), // R3
        .state_ff(rx_err_ff)
    );

    status_latch #(.LATCH_LOW(1'b0)) u_false_carrier (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .event_in(false_carrier_event),
        .clear(false_carrier_counter_read), // R5
        .state_ff(false_carrier_ff)
    );

    status_latch #(.LATCH_LOW(1'b0)) u_intr_pend (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .event_in(phy_intr_event),
        .clear(summary_read), // R9
        .state_ff(intr_pend_ff)
    );

    // Latch-low: a drop sticks low until a summary read lets it follow
    // the live level again; starts low after reset
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            signal_detect_ff <= 1'b0;
            descr_lock_ff <= 1'b0;
        end else begin
            signal_detect_ff <= pmd_sync[1] & (signal_detect_ff | summary_read); // R6
            descr_lock_ff <= pmd_sync[0] & (descr_lock_ff | summary_read); // R7
        end
    end

    // =====================================================================
    // Summary word assembly; mirrors are not cleared by our read
    always_comb begin
        summary_word = phy_status_pkg::summary_reset; // R2
        summary_word[phy_status_pkg::rx_err_bit] = rx_err_ff; // R3
        summary_word[phy_status_pkg::polarity_bit] = polarity_inverted; // R4
        summary_word[phy_status_pkg::false_carrier_bit] = false_carrier_ff; // R5
        summary_word[phy_status_pkg::signal_detect_bit] = signal_detect_ff; // R6
        summary_word[phy_status_pkg::descr_lock_bit] = descr_lock_ff; // R7
        summary_word[phy_status_pkg::page_rx_bit] = page_received; // R8
        summary_word[phy_status_pkg::intr_pend_bit] = intr_pend_ff; // R9
        summary_word[phy_status_pkg::remote_fault_bit] = remote_fault; // R10
        summary_word[phy_status_pkg::jabber_bit] = jabber_detect; // R11
        summary_word[phy_status_pkg::an_done_bit] = an_complete; // R12
        summary_word[phy_status_pkg::loopback_bit] = loopback_en; // R13
        summary_word[phy_status_pkg::duplex_bit] = duplex_full; // R14
        summary_word[phy_status_pkg::speed10_bit] = speed_10; // R15
        summary_word[phy_status_pkg::link_bit] = link_status; // R17
    end

    // =====================================================================
    // Checks
    chk_rx_err_set: assert property (@(posedge core_clk) disable iff (!rst_n) // R3
        rx_error_event |=> rx_err_ff)
        else $error("receive error latch did not set");

    chk_rx_err_clear: assert property (@(posedge core_clk) disable iff (!rst_n) // R3
        rx_err_counter_read && !rx_error_event |=> !rx_err_ff)
        else $error("receive error latch not cleared by counter read");

    chk_fc_clear: assert property (@(posedge core_clk) disable iff (!rst_n) // R5
        false_carrier_counter_read && !false_carrier_event |=> !false_carrier_ff)
        else $error("false carrier latch not cleared by counter read");

    chk_intr_read: assert property (@(posedge core_clk) disable iff (!rst_n) // R9
        summary_read && intr_pend_ff && !phy_intr_event
        |=> s_axi_rdata[phy_status_pkg::intr_pend_bit] && !intr_pend_ff)
        else $error("pending interrupt not returned then cleared");

    chk_sd_latch_low: assert property (@(posedge core_clk) disable iff (!rst_n) // R6
        !pmd_sync[1] ##1 (pmd_sync[1] && !summary_read)[*2] |-> !signal_detect_ff)
        else $error("signal detect did not stay latched low");

    chk_lock_low: assert property (@(posedge core_clk) disable iff (!rst_n) // R7
        !pmd_sync[0] |=> !descr_lock_ff)
        else $error("descrambler lock did not drop");

    chk_reserved_zero: assert property (@(posedge core_clk) disable iff (!rst_n) // R2
        $rose(s_axi_rvalid) |-> s_axi_rdata[31:14] == 18'h00000)
        else $error("reserved bits read nonzero");

    chk_link_mirror: assert property (@(posedge core_clk) disable iff (!rst_n) // R17
        summary_read |=> s_axi_rdata[phy_status_pkg::link_bit] == $past(link_status)
            && s_axi_rdata[phy_status_pkg::speed10_bit] == $past(speed_10))
        else $error("link or speed bit not mirrored");

    chk_write_resp: assert property (@(posedge core_clk) disable iff (!rst_n) // write response holds until accepted
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");

endmodule : phy_status_summary_reg

`default_nettype wire

// ===== rtl/status_latch.sv
`timescale 1ns/1ns
`default_nettype none

// =========================================================================
// Sticky status bit: latch-high or latch-low, set wins over clear
module status_latch #(
    parameter logic LATCH_LOW = 1'b0
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Event and clear
    input wire logic event_in,
    input wire logic clear,
    // State
    output logic state_ff
);

    // Event must beat a clear in the same cycle so nothing is lost
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_ff <= 1'b0;
        end else if (event_in) begin
            state_ff <= ~LATCH_LOW;
        end else if (clear) begin
            state_ff <= LATCH_LOW;
        end
    end

endmodule : status_latch

`default_nettype wire

// ===== rtl/sync2.sv
`timescale 1ns/1ns
`default_nettype none

// =========================================================================
// Two-flop synchroniser for a vector of pin levels
module sync2 #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_ff
);

    logic [WIDTH-1:0] meta_ff;

    // First stage is read only by the second stage
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

endmodule : sync2

`default_nettype wire

// ===== sim/testbench.sv
`timescale 1ns/1ns
`default_nettype none

module testbench;
    // =====================================================================
    // Ports of the block; inputs get their time-zero values here
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic rx_err_counter_read, false_carrier_counter_read, summary_read;
    logic [2:0] ev = 3'h0; // Receive error, false carrier, interrupt
    logic [1:0] pins = 2'h3; // Signal detect, descrambler lock
    logic [8:0] lv = 9'h000; // Mirrored levels, polarity down to link
    // =====================================================================
    // Bench state: expectation queues, counters, latch model
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    int failures = 0;
    int check_count = 0;
    logic [15:0] lfsr = 16'h782e;
    logic lat_rx = 1'b0, lat_fc = 1'b0, lat_int = 1'b0;
    logic [1:0] lat_ll = 2'h0;

    phy_status_summary_reg phy_status_summary_reg_i (
        .core_clk(core_clk), .rst_n(rst_n),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .rx_error_event(ev[2]), .false_carrier_event(ev[1]), .phy_intr_event(ev[0]),
        .polarity_inverted(lv[8]), .page_received(lv[7]), .remote_fault(lv[6]),
        .jabber_detect(lv[5]), .link_status(lv[0]), .an_complete(lv[4]),
        .loopback_en(lv[3]), .duplex_full(lv[2]), .speed_10(lv[1]),
        .signal_detect_pin(pins[1]), .descr_lock_pin(pins[0]),
        .rx_err_counter_read(rx_err_counter_read),
        .false_carrier_counter_read(false_carrier_counter_read), .summary_read(summary_read)
    );

    // Free-running 100 MHz clock
    initial begin
        forever #5 core_clk = ~core_clk;
    end

    // =====================================================================
    // Comparison and closing
    task check(input string name, input logic [33:0] seen, input logic [33:0] expected);
        check_count++;
        if (seen !== expected) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", name, expected, seen);
        end
    endtask : check

    task results();
        $display("checks %0d, failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : results

    // Summary word as the bench expects it from its own latch model
    function automatic logic [15:0] exp_word();
        return {2'b00, lat_rx, lv[8], lat_fc, lat_ll, lv[7], lat_int, lv[6:0]};
    endfunction : exp_word

    // =====================================================================
    // AXI4-Lite master; ready is read at the edge before anything moves
    task rd(input logic [7:0] addr, input logic [33:0] expected);
        int n;
        n = 0;
        rq.push_back(expected);
        s_axi_araddr <= addr;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (s_axi_arready !== 1'b1 && n < 50);
        check("clear strobes", {31'h0, rx_err_counter_read, false_carrier_counter_read,
            summary_read}, {31'h0, addr == phy_status_pkg::receive_error_counter_offset,
            addr == phy_status_pkg::false_carrier_counter_offset,
            addr == phy_status_pkg::summary_offset});
        s_axi_arvalid <= 1'b0;
        do begin
            @(posedge core_clk);
            n++;
        end while (s_axi_rvalid !== 1'b1 && n < 100);
        if (n >= 100) failures++;
        s_axi_rready <= 1'b0;
        @(posedge core_clk);
    endtask : rd

    task wr(input logic [7:0] addr, input logic [31:0] data, input logic [1:0] resp);
        int n;
        logic ad, wd;
        n = 0;
        ad = 1'b0;
        wd = 1'b0;
        bq.push_back(resp);
        s_axi_awaddr <= addr;
        s_axi_wdata <= data;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
            if (!ad && s_axi_awready === 1'b1) begin
                s_axi_awvalid <= 1'b0;
                ad = 1'b1;
            end
            if (!wd && s_axi_wready === 1'b1) begin
                s_axi_wvalid <= 1'b0;
                wd = 1'b1;
            end
        end while (!(ad && wd) && n < 50);
        do begin
            @(posedge core_clk);
            n++;
        end while (s_axi_bvalid !== 1'b1 && n < 100);
        if (n >= 100) failures++;
        s_axi_bready <= 1'b0;
        @(posedge core_clk);
    endtask : wr

    // Watcher: every answer that appears is matched to the oldest note
    always @(posedge core_clk) begin
        if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
            if (rq.size() > 0) check("read answer", {s_axi_rresp, s_axi_rdata}, rq.pop_front());
            else failures++;
        end
        if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
            if (bq.size() > 0) check("write answer", {32'h0, s_axi_bresp}, {32'h0, bq.pop_front()});
            else failures++;
        end
    end

    // =====================================================================
    // Scenario helpers
    task rd_sum();
        rd(phy_status_pkg::summary_offset, {phy_status_pkg::resp_okay, 16'h0000, exp_word()});
        lat_int = 1'b0;
    endtask : rd_sum

    // Reset clears every latch; latch-low bits rise only after one read
    task do_reset();
        rst_n <= 1'b0;
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        {lat_rx, lat_fc, lat_int, lat_ll} = 5'h00;
        repeat (5) @(posedge core_clk);
        rd_sum();
        lat_ll = 2'h3;
        rd_sum();
    endtask : do_reset

    task pulse(input int idx);
        ev[idx] <= 1'b1;
        @(posedge core_clk);
        ev[idx] <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask : pulse

    // =====================================================================
    // Main sequence
    initial begin
        do_reset();
        repeat (8) begin
            lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
            lv <= lfsr[8:0];
            repeat (3) @(posedge core_clk);
            rd_sum();
        end
        for (int i = 1; i < 3; i++) begin
            pulse(i);
            if (i == 2) lat_rx = 1'b1;
            else lat_fc = 1'b1;
            rd_sum();
            rd_sum();
            rd(i == 2 ? phy_status_pkg::receive_error_counter_offset :
                phy_status_pkg::false_carrier_counter_offset, {2'b10, 32'h0});
            {lat_rx, lat_fc} = 2'h0;
            rd_sum();
        end
        pulse(0);
        lat_int = 1'b1;
        rd_sum();
        rd_sum();
        for (int i = 0; i < 2; i++) begin
            pins[i] <= 1'b0;
            repeat (4) @(posedge core_clk);
            pins[i] <= 1'b1;
            repeat (6) @(posedge core_clk);
            lat_ll[i] = 1'b0;
            rd_sum();
            lat_ll[i] = 1'b1;
            rd_sum();
        end
        wr(phy_status_pkg::summary_offset, {lfsr, lfsr}, phy_status_pkg::resp_okay);
        rd_sum();
        wr(8'h10, 32'hffff_ffff, phy_status_pkg::resp_slverr);
        rd(8'h20, {phy_status_pkg::resp_slverr, phy_status_pkg::unmapped_read_value});
        pulse(2);
        pulse(0);
        do_reset();
        repeat (5) @(posedge core_clk);
        results();
    end

    // Watchdog: the sequence needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge core_clk);
        failures++;
        results();
    end
endmodule : testbench

`default_nettype wire
